// >>> fws_pkg.sv
package fws_pkg;
    localparam logic [11:0] OFF_CFG    = 12'h010;
    localparam logic [11:0] OFF_BEGIN  = 12'h020;
    localparam logic [11:0] OFF_END    = 12'h024;
    localparam logic [11:0] OFF_SIG0   = 12'h02c;
    localparam logic [11:0] OFF_SIG1   = 12'h030;
    localparam logic [11:0] OFF_SIG2   = 12'h034;
    localparam logic [11:0] OFF_SIG3   = 12'h038;
    localparam logic [11:0] OFF_STAT   = 12'hfe0;
    localparam logic [11:0] OFF_CLR    = 12'hfe8;
    localparam logic [11:0] OFF_VECTOR = 12'h040;
    localparam int          ADDR_W     = 17;
    localparam int          LAUNCH_BIT = 17;
    localparam int          DONE_BIT   = 2;
    localparam logic [1:0]  WAIT_RST   = 2'h2;
    localparam logic [1:0]  WAIT_1CYC  = 2'h0;
    localparam logic [1:0]  WAIT_2CYC  = 2'h1;
    localparam logic [1:0]  WAIT_3CYC  = 2'h2;
    localparam logic [1:0]  MAP_BOOT   = 2'h0;
    localparam logic [1:0]  MAP_FLASH  = 2'h1;
    localparam logic [1:0]  MAP_RAM    = 2'h2;
    localparam logic [31:0] BASE_BOOT  = 32'h1fff0000;
    localparam logic [31:0] BASE_FLASH = 32'h00000000;
    localparam logic [31:0] BASE_RAM   = 32'h10000000;
    localparam logic [31:0] VEC_OFF    = 32'h00000004;
    localparam int          TAP_A      = 0;
    localparam int          TAP_B      = 2;
    localparam int          TAP_C      = 27;
    localparam int          TAP_D      = 29;

    typedef struct packed {
        logic        req;
        logic [16:0] addr;
    } fws_frd_t;

    typedef struct packed {
        logic         valid;
        logic [127:0] data;
    } fws_fdat_t;
endpackage

// >>> fws_misr.sv
`timescale 1ns/1ns
module fws_misr (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clear,
    input  wire logic         shift,
    input  wire logic [127:0] data,
    output logic      [127:0] state
);
    logic [127:0] next;

    always_comb begin
        next = '0;
        for (int i = 0; i < 127; i++) begin
            next[i] = data[i] ^ state[i + 1];
        end
        next[127] = data[127] ^ state[fws_pkg::TAP_A] ^ state[fws_pkg::TAP_B]
                    ^ state[fws_pkg::TAP_C] ^ state[fws_pkg::TAP_D];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else if (clear) begin
            state <= '0;
        end else if (shift) begin
            state <= next;
        end
    end
endmodule // fws_misr

// >>> fws_wait.sv
`timescale 1ns/1ns
module fws_wait (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] wait_sel,
    input  wire logic       start,
    output logic            done
);
    logic [1:0] cnt_q;
    logic       busy_q;
    logic [1:0] last;

    always_comb begin
        unique case (wait_sel)
            fws_pkg::WAIT_1CYC: last = 2'h0;
            fws_pkg::WAIT_2CYC: last = 2'h1;
            default:            last = 2'h2;
        endcase
    end

    assign done = (start && last == 2'h0) || (busy_q && cnt_q == last);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 2'h0;
            busy_q <= 1'b0;
        end else if (done) begin
            busy_q <= 1'b0;
            cnt_q  <= 2'h0;
        end else if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= 2'h1;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule // fws_wait

// >>> fws_flash_ctrl.sv
`timescale 1ns/1ns
module fws_flash_ctrl (
    input  wire logic          REF_CLK,
    input  wire logic          RST_N,
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire logic [11:0]   PADDR,
    input  wire logic [31:0]   PWDATA,
    output logic      [31:0]   PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    input  wire logic          CPU_RD_REQ,
    input  wire logic [16:0]   CPU_RD_ADDR,
    output logic               CPU_RD_VALID,
    output logic      [127:0]  CPU_RD_DATA,
    input  wire logic [1:0]    MAP_MODE,
    output fws_pkg::fws_frd_t  FLASH_RD,
    input  wire fws_pkg::fws_fdat_t FLASH_DAT,
    output logic      [1:0]    ACCESS_WAIT,
    output logic               SIG_BUSY
);
    typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT} fws_state_t;

    fws_state_t   state_q;
    logic [1:0]   wait_q;
    logic [29:0]  cfg_rsv_q;
    logic [16:0]  begin_q;
    logic [16:0]  end_q;
    logic         launch_q;
    logic         done_q;
    logic [16:0]  addr_q;
    logic [127:0] sig_q;
    logic [127:0] misr_state;
    logic         misr_clear;
    logic         misr_shift;
    logic         wr_en;
    logic         rd_en;
    logic         launch_wr;
    logic         clr_wr;
    logic         run_done;
    logic         cpu_busy_q;
    logic         cpu_start;
    logic         cpu_done;
    logic         cpu_issue_q;
    logic [31:0]  rd_mux;
    logic         rd_hit;
    logic [31:0]  vec_base;

    assign wr_en     = PSEL && PENABLE && PWRITE && !PREADY;
    assign rd_en     = PSEL && PENABLE && !PWRITE && !PREADY;
    assign launch_wr = wr_en && PADDR == fws_pkg::OFF_END && PWDATA[fws_pkg::LAUNCH_BIT];
    assign clr_wr    = wr_en && PADDR == fws_pkg::OFF_CLR && PWDATA[fws_pkg::DONE_BIT];
    assign run_done  = state_q == S_WAIT && FLASH_DAT.valid && addr_q == end_q;

    // apb access phase, one wait cycle
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !rd_hit;
            if (rd_en) begin
                PRDATA <= rd_mux;
            end
        end
    end

    always_comb begin
        unique case (MAP_MODE)
            fws_pkg::MAP_BOOT:  vec_base = fws_pkg::BASE_BOOT;
            fws_pkg::MAP_RAM:   vec_base = fws_pkg::BASE_RAM;
            default:            vec_base = fws_pkg::BASE_FLASH;
        endcase
    end

    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        unique case (PADDR)
            fws_pkg::OFF_CFG:    rd_mux = {cfg_rsv_q, wait_q};
            fws_pkg::OFF_BEGIN:  rd_mux = {15'h0000, begin_q};
            fws_pkg::OFF_END:    rd_mux = {14'h0000, launch_q, end_q};
            fws_pkg::OFF_SIG0:   rd_mux = sig_q[31:0];
            fws_pkg::OFF_SIG1:   rd_mux = sig_q[63:32];
            fws_pkg::OFF_SIG2:   rd_mux = sig_q[95:64];
            fws_pkg::OFF_SIG3:   rd_mux = sig_q[127:96];
            fws_pkg::OFF_STAT:   rd_mux = {29'h00000000, done_q, 2'h0};
            fws_pkg::OFF_CLR:    rd_mux = 32'h00000000;
            fws_pkg::OFF_VECTOR: rd_mux = vec_base + fws_pkg::VEC_OFF;
            default:             rd_hit = !PWRITE ? 1'b0 : 1'b0;
        endcase
        if (PWRITE) begin
            rd_hit = PADDR == fws_pkg::OFF_CFG || PADDR == fws_pkg::OFF_BEGIN
                     || PADDR == fws_pkg::OFF_END || PADDR == fws_pkg::OFF_CLR;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_q    <= fws_pkg::WAIT_RST;
            cfg_rsv_q <= '0;
        end else if (wr_en && PADDR == fws_pkg::OFF_CFG) begin
            wait_q    <= PWDATA[1:0];
            cfg_rsv_q <= PWDATA[31:2];
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            begin_q <= '0;
            end_q   <= '0;
        end else if (wr_en && PADDR == fws_pkg::OFF_BEGIN) begin
            begin_q <= PWDATA[fws_pkg::ADDR_W-1:0];
        end else if (wr_en && PADDR == fws_pkg::OFF_END && state_q == S_IDLE) begin
            end_q <= PWDATA[fws_pkg::ADDR_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            launch_q <= 1'b0;
        end else if (run_done) begin
            launch_q <= 1'b0;
        end else if (launch_wr && state_q == S_IDLE) begin
            launch_q <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
            addr_q  <= '0;
        end else begin
            unique case (state_q)
                S_IDLE: if (launch_wr) begin
                    addr_q  <= begin_q;
                    state_q <= S_REQ;
                end
                S_REQ: state_q <= S_WAIT;
                S_WAIT: if (FLASH_DAT.valid) begin
                    if (addr_q == end_q) begin
                        state_q <= S_IDLE;
                    end else begin
                        addr_q  <= addr_q + 17'h00001;
                        state_q <= S_REQ;
                    end
                end
            endcase
        end
    end

    assign misr_clear = state_q == S_IDLE && launch_wr;
    assign misr_shift = state_q == S_WAIT && FLASH_DAT.valid;

    fws_misr u_misr (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .clear (misr_clear),
        .shift (misr_shift),
        .data  (FLASH_DAT.data),
        .state (misr_state)
    );

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sig_q <= '0;
        end else if (run_done) begin
            sig_q <= {FLASH_DAT.data[127] ^ misr_state[fws_pkg::TAP_A]
                      ^ misr_state[fws_pkg::TAP_B] ^ misr_state[fws_pkg::TAP_C]
                      ^ misr_state[fws_pkg::TAP_D],
                      FLASH_DAT.data[126:0] ^ misr_state[127:1]};
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            done_q <= 1'b0;
        end else if (run_done) begin
            done_q <= 1'b1;
        end else if (clr_wr) begin
            done_q <= 1'b0;
        end
    end

    // cpu reads stall while signature runs, a held request starts another read after each valid
    assign cpu_start = CPU_RD_REQ && !cpu_busy_q && !CPU_RD_VALID && state_q == S_IDLE
                       && !launch_wr;

    fws_wait u_wait (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .wait_sel (wait_q),
        .start    (cpu_issue_q),
        .done     (cpu_done)
    );

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cpu_busy_q   <= 1'b0;
            cpu_issue_q  <= 1'b0;
            CPU_RD_VALID <= 1'b0;
            CPU_RD_DATA  <= '0;
            FLASH_RD     <= '0;
            ACCESS_WAIT  <= fws_pkg::WAIT_RST;
            SIG_BUSY     <= 1'b0;
        end else begin
            ACCESS_WAIT  <= wait_q;
            SIG_BUSY     <= state_q != S_IDLE;
            CPU_RD_VALID <= cpu_done;
            // access time counts from the cycle the address is on the array
            cpu_issue_q  <= cpu_start;
            if (cpu_done) begin
                CPU_RD_DATA <= FLASH_DAT.data;
                cpu_busy_q  <= 1'b0;
            end else if (cpu_start) begin
                cpu_busy_q <= 1'b1;
            end
            if (state_q == S_REQ) begin
                FLASH_RD.req  <= 1'b1;
                FLASH_RD.addr <= addr_q;
            end else if (cpu_start) begin
                FLASH_RD.req  <= 1'b1;
                FLASH_RD.addr <= CPU_RD_ADDR;
            end else begin
                FLASH_RD.req <= 1'b0;
            end
        end
    end
endmodule // fws_flash_ctrl

// >>> fws_chk.sv
`timescale 1ns/1ns
module fws_chk (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        CPU_RD_REQ,
    input wire logic        CPU_RD_VALID,
    input wire logic [1:0]  ACCESS_WAIT,
    input wire logic        SIG_BUSY
);
    logic acc;
    logic hit;
    logic ro;
    assign acc = PSEL && PENABLE && !PREADY;
    assign hit = PADDR inside {12'h010, 12'h020, 12'h024, 12'h02c, 12'h030, 12'h034, 12'h038,
                               12'hfe0, 12'hfe8, 12'h040};
    assign ro = PADDR inside {12'h02c, 12'h030, 12'h034, 12'h038, 12'hfe0};
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    ready_latency_a: assert property (
        acc |=> PREADY) else $error("ready missing after access");
    ready_pulse_a: assert property (
        PREADY |=> !PREADY) else $error("ready held too long");
    err_with_ready_a: assert property (
        PSLVERR |-> PREADY) else $error("error without ready");
    unmapped_err_a: assert property (
        acc && !hit |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped access accepted");
    ro_write_err_a: assert property (
        acc && PWRITE && ro |=> PSLVERR) else $error("read-only write accepted");
    wait_follow_a: assert property (
        acc && PWRITE && PADDR == 12'h010 |-> ##2 ACCESS_WAIT == $past(PWDATA[1:0], 2))
        else $error("wait output not updated");
    cpu_one_a: assert property (
        $rose(CPU_RD_REQ) && !SIG_BUSY && ACCESS_WAIT == 2'h0 |=> !CPU_RD_VALID ##1 CPU_RD_VALID)
        else $error("one-cycle read late");
    cpu_two_a: assert property (
        $rose(CPU_RD_REQ) && !SIG_BUSY && ACCESS_WAIT == 2'h1
        |=> !CPU_RD_VALID [*2] ##1 CPU_RD_VALID)
        else $error("two-cycle read wrong");
    cpu_three_a: assert property (
        $rose(CPU_RD_REQ) && !SIG_BUSY && ACCESS_WAIT == 2'h2
        |=> !CPU_RD_VALID [*3] ##1 CPU_RD_VALID) else $error("three-cycle read wrong");
    launch_busy_a: assert property (
        acc && PWRITE && PADDR == 12'h024 && PWDATA[17] && !SIG_BUSY |-> ##[1:3] SIG_BUSY)
        else $error("launch did not start run");
endmodule // fws_chk
bind fws_flash_ctrl fws_chk fws_chk_i (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CPU_RD_REQ, .CPU_RD_VALID, .ACCESS_WAIT, .SIG_BUSY);

// >>> fws_flash_model.sv
`timescale 1ns/1ns
module fws_flash_model (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                slow,
    input wire fws_pkg::fws_frd_t   rd,
    output fws_pkg::fws_fdat_t      dat
);
    logic        pend_q;
    logic        valid_q;
    logic [1:0]  cnt_q;
    logic [16:0] addr_q;
    logic [16:0] cur;
    function automatic logic [127:0] word_of(input logic [16:0] a);
        return {a, a[14:0], ~a, a[14:0], a, a[14:0], ~a[14:0], a};
    endfunction
    // array shows the word of the address on the bus, valid comes self-timed
    assign cur = rd.req ? rd.addr : addr_q;
    assign dat = {valid_q, word_of(cur)};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            valid_q <= 1'b0;
            cnt_q <= 2'h0;
            addr_q <= 17'h0;
        end else begin
            valid_q <= 1'b0;
            if (rd.req) begin
                pend_q <= 1'b1;
                addr_q <= rd.addr;
                cnt_q <= slow ? 2'h3 : 2'h0;
            end else if (pend_q && cnt_q != 2'h0) begin
                cnt_q <= cnt_q - 2'h1;
            end else if (pend_q) begin
                pend_q <= 1'b0;
                valid_q <= 1'b1;
            end
        end
    end
endmodule // fws_flash_model

// >>> test_flash_wait_and_signature.sv
`timescale 1ns/1ns
module test_flash_wait_and_signature;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, cpu_req = 0, slow = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [16:0] cpu_addr = '0;
    logic [1:0] map_mode = '0, access_wait;
    logic pready, pslverr, cpu_valid, sig_busy, err;
    logic [127:0] cpu_data;
    fws_pkg::fws_frd_t frd;
    fws_pkg::fws_fdat_t fdat;
    int mismatches = 0, checked = 0;
    fws_flash_ctrl fws_flash_ctrl_i (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CPU_RD_REQ(cpu_req), .CPU_RD_ADDR(cpu_addr),
        .CPU_RD_VALID(cpu_valid), .CPU_RD_DATA(cpu_data), .MAP_MODE(map_mode), .FLASH_RD(frd),
        .FLASH_DAT(fdat), .ACCESS_WAIT(access_wait), .SIG_BUSY(sig_busy));
    fws_flash_model fws_flash_model_i (.clk(ref_clk), .rst_n(rst_n), .slow(slow), .rd(frd),
        .dat(fdat));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [127:0] word_of(input logic [16:0] a);
        return {a, a[14:0], ~a, a[14:0], a, a[14:0], ~a[14:0], a};
    endfunction
    function automatic logic [127:0] sig_of(input int b, input int e);
        logic [127:0] s;
        logic [127:0] d;
        logic [16:0] a;
        s = '0;
        for (int i = b; i <= e; i++) begin
            a = i[16:0];
            d = word_of(a);
            s = {d[127] ^ s[0] ^ s[2] ^ s[27] ^ s[29], d[126:0] ^ s[127:1]};
        end
        return s;
    endfunction
    task automatic t_reset();
        apb(1'b0, 12'h010, 32'h0);
        chk("wait field", 2'h2, rd[1:0]);
        chk("wait out", 2'h2, access_wait);
        apb(1'b0, 12'h020, 32'h0);
        chk("begin reset", 32'h0, rd);
        apb(1'b0, 12'h024, 32'h0);
        chk("end reset", 32'h0, rd);
        apb(1'b0, 12'hfe0, 32'h0);
        chk("status reset", 32'h0, rd);
        $display("test reset done");
    endtask
    task automatic t_wait();
        logic [31:0] cfg;
        int n;
        for (int c = 0; c < 4; c++) begin
            apb(1'b0, 12'h010, 32'h0);
            cfg = {rd[31:2], c[1:0]};
            apb(1'b1, 12'h010, cfg);
            apb(1'b0, 12'h010, 32'h0);
            chk("config", cfg, rd);
            chk("wait out", c[1:0], access_wait);
            n = 0;
            cpu_req <= 1'b1;
            cpu_addr <= 17'h7;
            do begin
                @(posedge ref_clk);
                n++;
            end while (cpu_valid !== 1'b1 && n < 20);
            cpu_req <= 1'b0;
            chk("read cycles", (c == 3) ? 5 : c + 3, n);
            chk("read data", word_of(17'h7), cpu_data);
        end
        $display("test wait done");
    endtask
    task automatic t_sig(input int b, input int e, input logic s);
        logic [127:0] exp;
        int n;
        exp = sig_of(b, e);
        slow <= s;
        apb(1'b1, 12'h020, b);
        apb(1'b1, 12'h024, 32'h20000 | e);
        n = 0;
        do begin
            apb(1'b0, 12'hfe0, 32'h0);
            n++;
        end while (rd[2] !== 1'b1 && n < 100);
        chk("done flag", 32'h4, rd);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'h02c + 12'(4 * i), 32'h0);
            chk("signature word", exp[32 * i +: 32], rd);
        end
        apb(1'b0, 12'h024, 32'h0);
        chk("end readback", e, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("begin readback", b, rd);
        apb(1'b1, 12'hfe8, 32'h4);
        apb(1'b0, 12'hfe0, 32'h0);
        chk("status cleared", 32'h0, rd);
        $display("test signature done");
    endtask
    task automatic t_err();
        logic [31:0] base [3] = '{32'h1fff0000, 32'h0, 32'h10000000};
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 12'hfe0, 32'hffffffff);
        chk("status write err", 1'b1, err);
        apb(1'b1, 12'h02c, 32'h1);
        chk("result write err", 1'b1, err);
        for (int m = 0; m < 3; m++) begin
            map_mode <= m[1:0];
            apb(1'b0, 12'h040, 32'h0);
            chk("vector word", base[m] + 32'h4, rd);
        end
        $display("test errors done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_wait();
        t_sig(3, 6, 1'b0);
        t_sig(9, 9, 1'b1);
        t_sig(131070, 131071, 1'b1);
        t_err();
        final_report();
    end
    initial begin
        #2000000;
        mismatches++;
        final_report();
    end
endmodule // test_flash_wait_and_signature
